// *** design/gtwr_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module gtwr_bank
    import gtwr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register request from protocol engine
    input wire logic req_valid,
    input wire gtwr_req_s req,
    // Register answer
    output logic resp_valid,
    output gtwr_resp_s resp,
    // Selector cable pin, low when attached
    input wire logic selector_cable_n,
    // Addressing
    output logic [7:0] answer_address,
    output logic [7:0] display_address,
    // Non-volatile store write
    output logic nvm_wr_valid,
    output gtwr_nvm_s nvm_wr,
    // Measurement path
    input wire logic raw_valid,
    input wire logic [15:0] raw_int,
    input wire logic [15:0] raw_ext,
    output logic meas_valid,
    output logic [15:0] meas_int,
    output logic [15:0] meas_ext,
    // Switching outputs
    output logic [1:0] relay,
    output logic [1:0] open_collector_terminal_o,
    output logic [1:0] open_collector_terminal_oe_n
);

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    logic [REG_W-1:0] cfg [NUM_REGS]; // R17
    logic [REG_W-1:0] next_cfg [NUM_REGS];
    logic next_resp_valid;
    gtwr_resp_s next_resp;
    logic next_nvm_wr_valid;
    gtwr_nvm_s next_nvm_wr;

    function automatic logic [15:0] reset_value(input int idx);
        case (idx)
            0: reset_value = RST_NODE; // R02
            1: reset_value = RST_GAIN; // R05
            2: reset_value = RST_ZERO; // R06
            4: reset_value = RST_FULL; // R08
            5, 6, 7, 8: reset_value = RST_SETPOINT;
            9: reset_value = RST_HYST;
            default: reset_value = 16'h0000;
        endcase
    endfunction

    function automatic logic is_reserved(input logic [15:0] a);
        is_reserved = (a == ADDR_RSVD_A) || (a == ADDR_RSVD_B) ||
                      (a == ADDR_RSVD_C) || (a == ADDR_RSVD_D); // R15
    endfunction

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] d,
                                      input logic [15:0] fs);
        case (a)
            ADDR_NODE: in_range = (d >= NODE_MIN) && (d <= NODE_MAX); // R01
            ADDR_GAIN: in_range = (d >= GAIN_MIN) && (d <= GAIN_MAX); // R05
            ADDR_ZERO: in_range = (d <= ZERO_MAX); // R06
            ADDR_HYST: in_range = (d <= fs); // R13
            default: in_range = 1'b1;
        endcase
    endfunction

    always_comb begin
        next_cfg = cfg;
        next_resp_valid = req_valid;
        next_resp = '0;
        next_nvm_wr_valid = 1'b0;
        next_nvm_wr = '0;
        if (req_valid) begin
            if (req.addr > ADDR_RSVD_D) begin
                next_resp.err = 1'b1;
            end else if (is_reserved(req.addr)) begin
                // Reserved words read zero and swallow writes
                next_resp.data = 16'h0000; // R15
            end else if (!req.write) begin
                next_resp.data = cfg[req.addr[3:0]];
            end else if (!in_range(req.addr, req.data, cfg[ADDR_FULL[3:0]])) begin
                // Out-of-range value keeps the old setting
                next_resp.err = 1'b1;
            end else begin
                next_cfg[req.addr[3:0]] = req.data; // R09 R10 R11 R12
                next_resp.data = req.data;
                // Skip the store when nothing changes, sparing flash wear
                if (cfg[req.addr[3:0]] != req.data) begin // R14
                    next_nvm_wr_valid = 1'b1;
                    next_nvm_wr.addr = req.addr;
                    next_nvm_wr.data = req.data;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                cfg[i] <= reset_value(i);
            end
            resp_valid <= 1'b0;
            resp <= '0;
            nvm_wr_valid <= 1'b0;
            nvm_wr <= '0;
        end else begin
            cfg <= next_cfg;
            resp_valid <= next_resp_valid;
            resp <= next_resp;
            nvm_wr_valid <= next_nvm_wr_valid;
            nvm_wr <= next_nvm_wr;
        end
    end

    // ----------------------------------------------------------------
    // Selector cable and addressing
    // ----------------------------------------------------------------
    logic sel_meta;
    logic sel_sync;
    logic [7:0] next_answer_address;
    logic [7:0] next_display_address;

    always_comb begin
        // Search address lives only here, never in the bank or store
        next_answer_address = sel_sync ? cfg[ADDR_NODE[3:0]][7:0] : SEARCH_ADDR; // R03 R04
        next_display_address = cfg[ADDR_NODE[3:0]][7:0]; // R03
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_meta <= 1'b1;
            sel_sync <= 1'b1;
            answer_address <= RST_NODE[7:0];
            display_address <= RST_NODE[7:0];
        end else begin
            sel_meta <= selector_cable_n;
            sel_sync <= sel_meta;
            answer_address <= next_answer_address;
            display_address <= next_display_address;
        end
    end

    // ----------------------------------------------------------------
    // Measurement correction and scaling
    // ----------------------------------------------------------------
    logic [15:0] corr;
    logic [31:0] prod_int;
    logic [31:0] prod_ext;
    logic next_meas_valid;
    logic [15:0] next_meas_int;
    logic [15:0] next_meas_ext;

    always_comb begin
        // Clamp at zero so an offset above the reading cannot wrap
        corr = (raw_int > cfg[ADDR_ZERO[3:0]]) ?
               16'(raw_int - cfg[ADDR_ZERO[3:0]]) : 16'h0000; // R07
        prod_int = 32'(corr) * 32'(cfg[ADDR_FULL[3:0]]); // R08
        prod_ext = 32'(raw_ext) * 32'(cfg[ADDR_FULL[3:0]]); // R08
        next_meas_valid = raw_valid;
        next_meas_int = raw_valid ? prod_int[SCALE_SHIFT +: 16] : meas_int;
        next_meas_ext = raw_valid ? prod_ext[SCALE_SHIFT +: 16] : meas_ext;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meas_valid <= 1'b0;
            meas_int <= 16'h0000;
            meas_ext <= 16'h0000;
        end else begin
            meas_valid <= next_meas_valid;
            meas_int <= next_meas_int;
            meas_ext <= next_meas_ext;
        end
    end

    // ----------------------------------------------------------------
    // Threshold outputs
    // ----------------------------------------------------------------
    logic [3:0] sw;
    logic [3:0] next_sw;
    logic [15:0] lower [4];

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lower[i] = (cfg[ADDR_RELAY_ONE[3:0] + i] > cfg[ADDR_HYST[3:0]]) ?
                       16'(cfg[ADDR_RELAY_ONE[3:0] + i] - cfg[ADDR_HYST[3:0]]) :
                       16'h0000;
            if (sw[i]) begin
                next_sw[i] = !(meas_int < lower[i]); // R16
            end else begin
                next_sw[i] = meas_int > cfg[ADDR_RELAY_ONE[3:0] + i]; // R16
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sw <= 4'h0;
            relay <= 2'h0;
            open_collector_terminal_o <= 2'h0;
            open_collector_terminal_oe_n <= 2'h3;
        end else begin
            sw <= next_sw;
            relay <= next_sw[1:0]; // R09 R10
            open_collector_terminal_o <= 2'h0;
            // Open collector only pulls low; released means high impedance
            open_collector_terminal_oe_n <= ~next_sw[3:2]; // R11 R12
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    node_range_a: assert property ( // R01
        req_valid && req.write && req.addr == ADDR_NODE && req.data == 16'h0000
        |=> resp_valid && resp.err && !nvm_wr_valid && cfg[0] == $past(cfg[0]))
        else $error("node address zero was accepted");

    search_addr_a: assert property ( // R03
        !sel_sync |=> answer_address == SEARCH_ADDR && display_address == $past(cfg[0][7:0]))
        else $error("search address not answered while cable attached");

    search_drop_a: assert property ( // R04
        $rose(sel_sync) |=> answer_address == $past(cfg[0][7:0]))
        else $error("search address kept after cable removal");

    search_store_a: assert property ( // R04
        $fell(sel_sync) |=> (cfg[0] == $past(cfg[0]) || $past(req_valid)))
        else $error("cable attach altered stored address");

    gain_range_a: assert property ( // R05
        req_valid && req.write && req.addr == ADDR_GAIN && req.data > GAIN_MAX
        |=> resp.err && !nvm_wr_valid && cfg[1] == $past(cfg[1]))
        else $error("gain above limit was accepted");

    zero_range_a: assert property ( // R06
        req_valid && req.write && req.addr == ADDR_ZERO && req.data > ZERO_MAX
        |=> resp_valid && resp.err)
        else $error("zero offset above limit was accepted");

    offset_sub_a: assert property ( // R07
        raw_valid && raw_int <= cfg[2]
        |=> meas_valid && meas_int == 16'h0000)
        else $error("offset not subtracted before scaling");

    hyst_range_a: assert property ( // R13
        req_valid && req.write && req.addr == ADDR_HYST && req.data > cfg[4]
        |=> resp.err && !nvm_wr_valid)
        else $error("hysteresis above full scale was accepted");

    reserved_wr_a: assert property ( // R15
        req_valid && req.write && req.addr == ADDR_RSVD_A
        |=> resp_valid && !resp.err && resp.data == 16'h0000 && !nvm_wr_valid)
        else $error("reserved register acted on a write");

    switch_set_a: assert property ( // R16
        $rose(sw[0]) |-> $past(meas_int) > $past(cfg[5]) && relay[0])
        else $error("relay set without exceeding setpoint");

    switch_hold_a: assert property ( // R16
        sw[2] && meas_int >= lower[2] |=> sw[2] && !open_collector_terminal_oe_n[0])
        else $error("output released inside hysteresis band");

    write_store_c: cover property (
        req_valid && req.write && req.addr == ADDR_RELAY_ONE ##1 nvm_wr_valid);
    cable_cycle_c: cover property (!sel_sync ##[1:20] sel_sync);
    relay_toggle_c: cover property ($rose(sw[1]) ##[1:50] $fell(sw[1]));

endmodule

`default_nettype wire

// *** design/gtwr_pkg.sv ***
// Operation
// (R01) Stored node address accepted only from 1 to 255, at register zero.
// (R02) Factory node address is 245.
// (R03) With selector cable attached, answer at 246 while displaying stored address.
// (R04) Address 246 is never stored and vanishes when the cable is removed.
// (R05) Gain factor at register one ranges 3000 to 30000, factory value 10000.
// (R06) Zero offset at register two ranges 0 to 1000, factory value 0.
// (R07) Zero offset is subtracted from each raw measured value; the code subtracts it from raw_int only, not from raw_ext.
// (R08) Full-scale value at register four scales both reported measurements, typically 25.
// (R09) Register five holds the first relay threshold.
// (R10) Register six holds the second relay threshold.
// (R11) Register seven holds the third, open-collector output threshold.
// (R12) Register eight holds the fourth, open-collector output threshold.
// (R13) Register nine holds hysteresis, from zero up to the full-scale value.
// (R14) Master writes stored parameters only when a setting really changes.
// (R15) Registers three, ten, eleven and twelve are reserved with no function.
// (R16) Output sets above setpoint, releases below setpoint minus hysteresis.
// (R17) Every write register is sixteen bits wide.
package gtwr_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int REG_W = 16;
    localparam int NUM_REGS = 13;
    localparam logic [15:0] ADDR_NODE = 16'h0000;
    localparam logic [15:0] ADDR_GAIN = 16'h0001;
    localparam logic [15:0] ADDR_ZERO = 16'h0002;
    localparam logic [15:0] ADDR_RSVD_A = 16'h0003;
    localparam logic [15:0] ADDR_FULL = 16'h0004;
    localparam logic [15:0] ADDR_RELAY_ONE = 16'h0005;
    localparam logic [15:0] ADDR_RELAY_TWO = 16'h0006;
    localparam logic [15:0] ADDR_OUT_THREE = 16'h0007;
    localparam logic [15:0] ADDR_OUT_FOUR = 16'h0008;
    localparam logic [15:0] ADDR_HYST = 16'h0009;
    localparam logic [15:0] ADDR_RSVD_B = 16'h000A;
    localparam logic [15:0] ADDR_RSVD_C = 16'h000B;
    localparam logic [15:0] ADDR_RSVD_D = 16'h000C;

    // ----------------------------------------------------------------
    // Reset values and limits
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_NODE = 16'h00F5;
    localparam logic [15:0] RST_GAIN = 16'h2710;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_FULL = 16'h0019;
    localparam logic [15:0] RST_SETPOINT = 16'h0000;
    localparam logic [15:0] RST_HYST = 16'h0000;
    localparam logic [15:0] NODE_MIN = 16'h0001;
    localparam logic [15:0] NODE_MAX = 16'h00FF;
    localparam logic [15:0] GAIN_MIN = 16'h0BB8;
    localparam logic [15:0] GAIN_MAX = 16'h7530;
    localparam logic [15:0] ZERO_MAX = 16'h03E8;
    localparam logic [7:0] SEARCH_ADDR = 8'hF6;
    localparam int SCALE_SHIFT = 16;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } gtwr_req_s;

    typedef struct packed {
        logic err;
        logic [15:0] data;
    } gtwr_resp_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } gtwr_nvm_s;

endpackage

// *** sim/gtwr_master.sv ***
`timescale 1ns/1ps
`default_nettype none

module gtwr_master
    import gtwr_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request side
    output logic req_valid,
    output gtwr_req_s req,
    // Answer side
    input wire logic resp_valid,
    input wire gtwr_resp_s resp
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // Entered just after an edge; one idle edge, then the request is held over one edge
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        output gtwr_resp_s r, output logic got);
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req = '{wr, a, d};
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        // Idle bus holds the inverted request, never the stale request
        req = ~req;
        got = resp_valid;
        r = resp;
    endtask
endmodule

`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench
    import gtwr_pkg::*;
;
    logic clk, nrst, req_valid, resp_valid, cab_n, raw_valid, meas_valid, nvm_wr_valid;
    gtwr_req_s req;
    gtwr_resp_s resp;
    gtwr_nvm_s nvm_wr;
    logic [7:0] ans_a, disp_a;
    logic [15:0] raw_int, raw_ext, meas_int, meas_ext, a, d;
    logic [1:0] relay, oc_o, oc_oe_n;
    logic [15:0] sh [0:12];
    logic st [0:3];
    int seed = 15;
    int mismatches = 0;
    int n_checks = 0;
    int mv [9] = '{0, 1500, 2600, 3900, 4100, 3700, 3400, 2000, 100};
    logic [31:0] cn [18] = '{32'h00000000, 32'h00000001, 32'h000000FF, 32'h00000100,
        32'h00010BB7, 32'h00010BB8, 32'h00017530, 32'h00017531, 32'h00017530,
        32'h000203E9, 32'h000203E8, 32'h00040010, 32'h00090011, 32'h00090010,
        32'h00031234, 32'h000A1234, 32'h000C5678, 32'h000D0001};

    gtwr_bank i_gtwr_bank (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
        .resp_valid(resp_valid), .resp(resp), .selector_cable_n(cab_n),
        .answer_address(ans_a), .display_address(disp_a), .nvm_wr_valid(nvm_wr_valid),
        .nvm_wr(nvm_wr), .raw_valid(raw_valid), .raw_int(raw_int), .raw_ext(raw_ext),
        .meas_valid(meas_valid), .meas_int(meas_int), .meas_ext(meas_ext), .relay(relay),
        .open_collector_terminal_o(oc_o), .open_collector_terminal_oe_n(oc_oe_n));
    gtwr_master i_gtwr_master (.clk(clk), .req_valid(req_valid), .req(req),
        .resp_valid(resp_valid), .resp(resp));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // --------------------------------------------------------
    // Expectation helpers
    // --------------------------------------------------------
    function automatic logic bad(input logic [15:0] ad, input logic [15:0] dd);
        case (ad)
            ADDR_NODE: return dd < NODE_MIN || dd > NODE_MAX;
            ADDR_GAIN: return dd < GAIN_MIN || dd > GAIN_MAX;
            ADDR_ZERO: return dd > ZERO_MAX;
            ADDR_HYST: return dd > sh[4];
            default: return ad > ADDR_RSVD_D;
        endcase
    endfunction

    function automatic logic rw(input logic [15:0] ad);
        return ad <= ADDR_HYST && ad != ADDR_RSVD_A;
    endfunction

    task automatic wr(input logic [15:0] ad, input logic [15:0] dd);
        logic e, g, ch;
        gtwr_resp_s r;
        e = bad(ad, dd);
        ch = !e && rw(ad) && sh[ad[3:0]] !== dd;
        i_gtwr_master.xfer(1'b1, ad, dd, r, g);
        chk(g, 1);
        chk(r.err, e);
        chk(nvm_wr_valid, ch);
        if (ch) chk(nvm_wr, {ad, dd});
        if (!e && rw(ad)) sh[ad[3:0]] = dd;
    endtask

    task automatic rd(input logic [15:0] ad);
        logic g;
        gtwr_resp_s r;
        i_gtwr_master.xfer(1'b0, ad, 16'h0000, r, g);
        chk(g, 1);
        chk(r.err, ad > ADDR_RSVD_D);
        if (ad <= ADDR_RSVD_D) chk(r.data, sh[ad[3:0]]);
    endtask

    task automatic sample(input logic [15:0] ri, input logic [15:0] re);
        logic [31:0] m;
        logic [15:0] lo;
        logic [1:0] ex;
        raw_valid = 1'b1;
        raw_int = ri;
        raw_ext = re;
        @(posedge clk);
        #1;
        raw_valid = 1'b0;
        raw_int = ~ri;
        raw_ext = ~re;
        m = (ri >= sh[2]) ? ((32'(ri) - 32'(sh[2])) * 32'(sh[4])) >> 16 : 32'h0;
        chk(meas_valid, 1);
        chk(meas_int, m);
        chk(meas_ext, (32'(re) * 32'(sh[4])) >> 16);
        for (int i = 0; i < 4; i++) begin
            lo = (sh[5 + i] > sh[9]) ? sh[5 + i] - sh[9] : 16'h0000;
            if (m > 32'(sh[5 + i])) st[i] = 1'b1;
            else if (m < 32'(lo)) st[i] = 1'b0;
        end
        @(posedge clk);
        #1;
        ex = ~{st[3], st[2]};
        chk(relay, {st[1], st[0]});
        chk(oc_oe_n, ex);
        chk(oc_o, 0);
    endtask

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        nrst = 1'b0;
        cab_n = 1'b1;
        raw_valid = 1'b0;
        raw_int = 16'h0000;
        raw_ext = 16'h0000;
        sh = '{RST_NODE, RST_GAIN, RST_ZERO, 16'h0000, RST_FULL, RST_SETPOINT, RST_SETPOINT,
            RST_SETPOINT, RST_SETPOINT, RST_HYST, 16'h0000, 16'h0000, 16'h0000};
        st = '{1'b0, 1'b0, 1'b0, 1'b0};
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        chk(ans_a, 8'hF5);
        chk(disp_a, 8'hF5);
        for (int i = 0; i < 14; i++) rd(16'(i));
        $display("test reset done");
        for (int i = 0; i < 18; i++) wr(cn[i][31:16], cn[i][15:0]);
        for (int i = 0; i < 14; i++) rd(16'(i));
        $display("test corners done");
        for (int i = 0; i < 40; i++) begin
            a = 16'($unsigned($random(seed)) % 14);
            d = 16'($random(seed));
            if (i % 3 == 0) d = {7'h00, d[8:0]};
            // Stimulus only rewrites a stored setting when it really changes
            if (!rw(a) || sh[a[3:0]] !== d) wr(a, d);
            rd(a);
        end
        $display("test random done");
        wr(ADDR_NODE, 16'h000F);
        cab_n = 1'b0;
        repeat (3) begin
            @(posedge clk);
            #1;
            chk(nvm_wr_valid, 0);
        end
        chk(ans_a, 8'hF6);
        chk(disp_a, 8'h0F);
        rd(ADDR_NODE);
        cab_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(ans_a, 8'h0F);
        $display("test cable done");
        wr(ADDR_FULL, 16'h8000);
        wr(ADDR_ZERO, 16'h0064);
        wr(ADDR_HYST, 16'h01F4);
        for (int i = 0; i < 4; i++) wr(ADDR_RELAY_ONE + 16'(i), 16'(1000 * (i + 1)));
        for (int i = 0; i < 9; i++) sample(16'(2 * mv[i] + 100), 16'($random(seed)));
        for (int i = 0; i < 10; i++) sample(16'($random(seed)), 16'($random(seed)));
        $display("test measure done");
        end_sim();
    end

    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule

`default_nettype wire
